// ---- ige_pkg.sv ----
// Shared constants and types of the serial-bus I/O expander
package ige_pkg;

  // Port geometry
  localparam int PORT_W = 8;
  localparam int NPORTS = 3;

  // Clock rate and serial-bus timing
  localparam int CLK_HZ = 25_000_000;
  localparam int FAST_SCL_HZ = 400_000;
  localparam int MIN_OVERSAMPLE = 16;
  localparam int SPIKE_NS = 50;
  // Longest spike to reject, rounded down, never under one cycle
  localparam int SPIKE_CYC_RAW = (SPIKE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
  localparam int MAX_FILT = 14;

  // Command byte layout
  localparam int CMD_AUTOINC_BIT = 7;
  localparam int CMD_BANK_LSB = 2;
  localparam int CMD_PORT_LSB = 0;
  localparam logic [7:0] CMD_RST = 8'h00;

  // Register banks selected by the command byte
  localparam logic [1:0] BANK_IN = 2'h0;
  localparam logic [1:0] BANK_OUT = 2'h1;
  localparam logic [1:0] BANK_POL = 2'h2;
  localparam logic [1:0] BANK_DIR = 2'h3;

  // Values after reset; direction bit set means input
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] IN_RST = 8'h00;

  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Register bus byte offsets
  localparam logic [3:0] OFS_STAT = 4'h0;
  localparam logic [3:0] OFS_EN = 4'h4;
  localparam logic [3:0] OFS_CLR = 4'h8;
  localparam logic [3:0] OFS_INFO = 4'hC;

  // Event bits of status, enable and clear
  localparam int EV_W = 4;
  localparam int EV_CHG = 0;
  localparam int EV_WR = 1;
  localparam int EV_RD = 2;
  localparam int EV_MATCH = 3;
  localparam logic [3:0] EN_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WR, ST_ACK, ST_RD, ST_MACK
  } ige_state_type;

endpackage

// ---- ige_filt.sv ----
// Two-flop synchroniser with spike filter for one pin
`timescale 1ns/1ns

module ige_filt
  import ige_pkg::*;
#(
  parameter int FILT_CYC = SPIKE_CYC,
  parameter logic RST_VAL = 1'b1
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d_i,
  output logic q_o
);
  localparam int CW = $clog2(FILT_CYC + 2);

  logic s1_q, s2_q, q_q, q_d, hit;
  logic [CW-1:0] cnt_q, cnt_d;

  // A change must persist FILT_CYC+1 samples before it passes
  assign hit = (s2_q != q_q) && (cnt_q == CW'(FILT_CYC));
  assign cnt_d = ((s2_q == q_q) || hit) ? '0 : cnt_q + 1'b1;
  assign q_d = hit ? s2_q : q_q;
  assign q_o = q_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      q_q <= RST_VAL;
      cnt_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      q_q <= q_d;
      cnt_q <= cnt_d;
    end
  end

endmodule // ige_filt

// ---- ige_port.sv ----
// One 8-line port: direction, output, polarity and input capture
`timescale 1ns/1ns

module ige_port
  import ige_pkg::*;
#(
  parameter int W = PORT_W
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_i,
  input wire logic wr_en,
  input wire logic [1:0] bank,
  input wire logic [W-1:0] wr_data,
  input wire logic snap,
  output logic [W-1:0] rd_data,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe,
  output logic changed
);
  logic [W-1:0] s1_q, s2_q, in_q, out_q, pol_q, drv_q;
  logic primed_q;
  logic [W-1:0] live;

  // Reads of the input bank return the pins as captured now
  assign live = s2_q ^ pol_q;
  assign rd_data = (bank == BANK_IN) ? live :
                   (bank == BANK_OUT) ? out_q :
                   (bank == BANK_POL) ? pol_q : ~drv_q;
  // No change is reported before the capture has been primed
  assign changed = primed_q && |((s2_q ^ in_q) & ~drv_q);
  assign pin_o = out_q;
  assign pin_oe = drv_q;

  // Synchroniser runs through reset so priming sees real pin levels
  always_ff @(posedge clk) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_q <= IN_RST[W-1:0];
      out_q <= OUT_RST[W-1:0];
      pol_q <= POL_RST[W-1:0];
      drv_q <= ~DIR_RST[W-1:0];
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
      if (snap || !primed_q) in_q <= s2_q;
      if (wr_en && bank == BANK_OUT) out_q <= wr_data;
      if (wr_en && bank == BANK_POL) pol_q <= wr_data;
      if (wr_en && bank == BANK_DIR) drv_q <= ~wr_data;
    end
  end

endmodule // ige_port

// ---- ige_top.sv ----
// Top level of the 24-line serial-bus I/O expander
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns

// How it works
// - Three 8-line ports, each with direction, input, output, polarity.
// - After reset every line is an input and no line is driven.
// - The master picks each line's direction by writing its bit.
// - Input bytes hold captured pins; output bytes hold driven values.
// - A set polarity bit makes the input byte read inverted.
// - Every register can be read back over the serial bus.
// - Power-on reset restores defaults and idles the bus machine.
// - The reset pin performs the same initialisation while powered; register-bus registers keep their values.
// - Interrupt is driven low while an input pin differs from capture.
// - The target address takes its low bit from the address pin.
// - The target keeps up with a 400 kHz serial clock.
// - Clock and data inputs are spike-filtered before the protocol.
module ige_top
  import ige_pkg::*;
#(
  parameter logic [5:0] BASE_ADDR = 6'h11, // Arbitrary neutral value
  parameter int FILT_CYC = SPIKE_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_rst_n,
  input wire logic addr_sel,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_n_o,
  output logic int_n_oe,
  input wire logic [NPORTS*PORT_W-1:0] p_i,
  output logic [NPORTS*PORT_W-1:0] p_o,
  output logic [NPORTS*PORT_W-1:0] p_oe,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  localparam int PW = PORT_W;
  localparam int NP = NPORTS;
  localparam logic [1:0] PORT_LAST = 2'(NP - 1);

  // Elaboration checks
  if (CLK_HZ < MIN_OVERSAMPLE * FAST_SCL_HZ) begin : g_rate_chk
    $error("Clock too slow to oversample a fast-mode bus");
  end
  if (FILT_CYC < 0 || FILT_CYC > MAX_FILT) begin : g_filt_chk
    $error("Filter length out of range");
  end
  if (NP < 1 || NP > 3 || PW != 8) begin : g_geom_chk
    $error("Port geometry not supported by the command byte");
  end

  // Pin conditioning
  logic scl_f, sda_f, hw_rst_f, addr_f;
  logic dev_rst_n;

  ige_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b1)) u_scl_filt (
    .clk(clk),
    .rst_n(rst_n),
    .d_i(scl_i),
    .q_o(scl_f)
  );
  ige_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b1)) u_sda_filt (
    .clk(clk),
    .rst_n(rst_n),
    .d_i(sda_i),
    .q_o(sda_f)
  );
  ige_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b1)) u_rst_filt (
    .clk(clk),
    .rst_n(rst_n),
    .d_i(hw_rst_n),
    .q_o(hw_rst_f)
  );
  ige_filt #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b0)) u_addr_filt (
    .clk(clk),
    .rst_n(rst_n),
    .d_i(addr_sel),
    .q_o(addr_f)
  );

  // Reset pin repeats the power-on initialisation of ports, bus machine and interrupt
  assign dev_rst_n = rst_n & hw_rst_f;

  // Bus conditions
  logic scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_w, stop_w;

  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_w = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_w = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // Protocol state
  ige_state_type state_q, state_d, next_q, next_d;
  logic [7:0] shift_q, shift_d, tx_q, tx_d, cmd_q, cmd_d;
  logic [3:0] cnt_q, cnt_d;
  logic oe_q, oe_d, ack_ok_q, ack_ok_d;

  logic byte_done, addr_match, wr_pulse, load_w, rd_acked;
  logic [1:0] port_idx, bank, nxt_idx;
  logic [7:0] cmd_adv, rd_byte;
  logic [PW-1:0] rd_arr [NP];
  logic [NP-1:0] chg;

  assign port_idx = cmd_q[CMD_PORT_LSB +: 2];
  assign bank = cmd_q[CMD_BANK_LSB +: 2];
  assign nxt_idx = (port_idx >= PORT_LAST) ? 2'h0 : port_idx + 2'h1;
  assign cmd_adv = cmd_q[CMD_AUTOINC_BIT] ?
                   {cmd_q[7:2], nxt_idx} : cmd_q;
  assign rd_byte = (port_idx < 2'(NP)) ? rd_arr[port_idx] : 8'h00;

  assign byte_done = scl_fall && (cnt_q == BYTE_BITS);
  assign addr_match = (shift_q[7:1] == {BASE_ADDR, addr_f});
  assign wr_pulse = byte_done && (state_q == ST_WR);
  assign rd_acked = scl_rise && (state_q == ST_MACK) && !sda_f;
  // Capture moments: first data byte of a read, and each later one
  assign load_w = (byte_done && state_q == ST_ADDR && addr_match &&
                   shift_q[0]) ||
                  (scl_fall && state_q == ST_MACK && ack_ok_q);

  always_comb begin
    state_d = state_q;
    next_d = next_q;
    shift_d = shift_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    ack_ok_d = ack_ok_q;
    if (stop_w) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (start_w) begin
      // Repeated start keeps the command byte
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_CMD, ST_WR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_d = 4'h0;
            if (state_q != ST_ADDR || addr_match) begin
              state_d = ST_ACK;
              oe_d = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
            if (state_q == ST_ADDR) begin
              next_d = shift_q[0] ? ST_RD : ST_CMD;
              tx_d = rd_byte;
            end else if (state_q == ST_CMD) begin
              cmd_d = shift_q;
              next_d = ST_WR;
            end else begin
              cmd_d = cmd_adv;
              next_d = ST_WR;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_d = next_q;
            if (next_q == ST_RD) begin
              oe_d = ~tx_q[7];
              cnt_d = 4'h1;
            end else begin
              oe_d = 1'b0;
              cnt_d = 4'h0;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_q == BYTE_BITS) begin
              // Release data so the master can acknowledge
              oe_d = 1'b0;
              cnt_d = 4'h0;
              state_d = ST_MACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = ~tx_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            ack_ok_d = ~sda_f;
            if (!sda_f) cmd_d = cmd_adv;
          end else if (scl_fall) begin
            if (ack_ok_q) begin
              tx_d = rd_byte;
              oe_d = ~rd_byte[7];
              cnt_d = 4'h1;
              state_d = ST_RD;
            end else begin
              // No acknowledge ends the read; wait for stop or start
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!dev_rst_n) begin
      state_q <= ST_IDLE;
      next_q <= ST_IDLE;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= CMD_RST;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
      ack_ok_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      state_q <= state_d;
      next_q <= next_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      ack_ok_q <= ack_ok_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // The three ports
  for (genvar i = 0; i < NP; i++) begin : g_port
    logic sel;
    assign sel = (port_idx == 2'(i));
    ige_port #(.W(PW)) u_port (
      .clk(clk),
      .rst_n(dev_rst_n),
      .pin_i(p_i[i*PW +: PW]),
      .wr_en(wr_pulse && sel),
      .bank(bank),
      .wr_data(shift_q),
      .snap(load_w && sel && bank == BANK_IN),
      .rd_data(rd_arr[i]),
      .pin_o(p_o[i*PW +: PW]),
      .pin_oe(p_oe[i*PW +: PW]),
      .changed(chg[i])
    );
  end

  // Open-drain outputs drive low only
  logic sda_lo_q, int_lo_q, int_q, chg_p_q;
  logic chg_any;

  assign chg_any = |chg;
  assign sda_o = sda_lo_q;
  assign sda_oe = oe_q;
  assign int_n_o = int_lo_q;
  assign int_n_oe = int_q;

  always_ff @(posedge clk) begin
    if (!dev_rst_n) begin
      sda_lo_q <= 1'b0;
      int_lo_q <= 1'b0;
      int_q <= 1'b0;
      chg_p_q <= 1'b0;
    end else begin
      sda_lo_q <= 1'b0;
      int_lo_q <= 1'b0;
      int_q <= chg_any;
      chg_p_q <= chg_any;
    end
  end

  // Register bus slave: one wait cycle, then the answer
  logic wait_q, ack_w;
  logic [31:0] rdata_q, rdata_d;
  logic [EV_W-1:0] stat_q, stat_d, en_q, clr_w, ev_w;
  logic irq_q;
  logic sel_stat, sel_en, sel_clr, sel_info;
  logic [31:0] info_w;

  assign sel_stat = (avs_address == OFS_STAT);
  assign sel_en = (avs_address == OFS_EN);
  assign sel_clr = (avs_address == OFS_CLR);
  assign sel_info = (avs_address == OFS_INFO);
  assign ack_w = (avs_read || avs_write) && !wait_q;

  assign info_w = {21'h000000, int_q, addr_f, state_q != ST_IDLE, cmd_q};
  // Unmapped and write-only offsets read as zero
  assign rdata_d = sel_stat ? {{(32 - EV_W){1'b0}}, stat_q} :
                   sel_en ? {{(32 - EV_W){1'b0}}, en_q} :
                   sel_info ? info_w : 32'h00000000;

  assign ev_w[EV_CHG] = chg_any && !chg_p_q;
  assign ev_w[EV_WR] = wr_pulse;
  assign ev_w[EV_RD] = rd_acked;
  assign ev_w[EV_MATCH] = byte_done && state_q == ST_ADDR && addr_match;
  assign clr_w = (ack_w && avs_write && sel_clr) ?
                 avs_writedata[EV_W-1:0] : '0;
  // A new event outranks a clear in the same cycle
  assign stat_d = (stat_q & ~clr_w) | ev_w;

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign irq = irq_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      stat_q <= '0;
      en_q <= EN_RST;
      irq_q <= 1'b0;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) rdata_q <= rdata_d;
      if (ack_w && avs_write && sel_en) en_q <= avs_writedata[EV_W-1:0];
      stat_q <= stat_d;
      irq_q <= |(stat_d & en_q);
    end
  end

endmodule // ige_top

// ---- ige_top_props.sv ----
// Port-level assertions for the serial-bus I/O expander
`timescale 1ns/1ns

module ige_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_rst_n,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_n_o,
  input wire logic int_n_oe,
  input wire logic [23:0] p_i,
  input wire logic [23:0] p_o,
  input wire logic [23:0] p_oe,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_por_defaults:
    assert property (@(posedge clk) disable iff (1'b0) !rst_n |=>
      p_oe == 24'h0 && p_o == 24'h0 && !int_n_oe && !sda_oe && !irq)
    else $error("Outputs not at defaults after reset");
  a_pin_reset:
    assert property (!hw_rst_n [*8] |-> p_oe == 24'h0 && p_o == 24'h0
      && !int_n_oe && !sda_oe)
    else $error("Reset pin did not initialise the ports");
  a_one_wait:
    assert property (s_taken |=> s_answer)
    else $error("Access not answered after one wait cycle");
  a_wait_idle:
    assert property (!avs_read && !avs_write && avs_waitrequest
      |=> avs_waitrequest)
    else $error("Wait request dropped without a request");
  a_rdata_hold:
    assert property (!(avs_read && avs_waitrequest)
      |=> $stable(avs_readdata))
    else $error("Read data changed without a read");
  a_int_drain:
    assert property (int_n_oe |-> !int_n_o)
    else $error("Interrupt line driven high");
  a_sda_drain:
    assert property (sda_oe |-> !sda_o)
    else $error("Data line driven high");
  a_int_cause:
    assert property ($rose(int_n_oe) |-> $past(p_i, 2) != $past(p_i, 6))
    else $error("Interrupt raised without an input change");
endmodule // ige_chk

// ---- ige_i2c_mst.sv ----
// Behavioural serial-bus master owning the clock, sharing the data wire
`timescale 1ns/1ns

module ige_i2c_mst (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Clock stands high between frames
  task automatic start();
    sda_m <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Clock pulse with data a before the rise, b during high: P or Sr
  task automatic cond(input logic a, input logic b);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
    sda_m <= a;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_m <= b;
    repeat (4) @(posedge clk);
  endtask

  // Eight cycles per bit; late sample since the target answers slowly
  task automatic bit_x(input logic d, output logic q);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
    sda_m <= d;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    q = sda_w;
    @(posedge clk);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_x(b[i], q);
    bit_x(1'b1, ack);
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    // Acknowledge slot must not overwrite the data byte
    bit_x(last, q);
  endtask
endmodule // ige_i2c_mst

// ---- tb.sv ----
// Self-checking bench of the serial-bus I/O expander
`timescale 1ns/1ns

module tb
  import ige_pkg::*;
;
  localparam logic [5:0] BASE = 6'h11; // Arbitrary address base
  logic clk = 1'b0;
  logic rst_n, hw_rst_n, addr_sel, scl, sda_m, sda_w, sda_o, sda_oe;
  logic int_n_o, int_n_oe, avs_read, avs_write, avs_waitrequest, irq;
  logic ack;
  logic [23:0] p_i, p_o, p_oe, ext_q, rv;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int error_cnt = 0;
  int check_count = 0;

  // Pulled-up data wire; driven port lines read back their own value
  assign sda_w = sda_m & ~sda_oe;
  assign p_i = (p_oe & p_o) | (~p_oe & ext_q);

  always #20 clk = ~clk;

  ige_top #(.BASE_ADDR(BASE), .FILT_CYC(SPIKE_CYC)) dut_u (
    .clk(clk), .rst_n(rst_n), .hw_rst_n(hw_rst_n), .addr_sel(addr_sel),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe), .p_i(p_i), .p_o(p_o),
    .p_oe(p_oe), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq));
  ige_i2c_mst mst_u (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic av(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // Request stands until an edge that shows waitrequest low
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = avs_readdata;
    if (n == 20) begin
      error_cnt++;
      end_of_test();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic i2c_head(input logic [7:0] cmd);
    @(posedge clk);
    mst_u.start();
    mst_u.wr_byte({BASE, addr_sel, 1'b0}, ack);
    check("addr ack", ack, 32'h0);
    mst_u.wr_byte(cmd, ack);
    check("cmd ack", ack, 32'h0);
  endtask

  task automatic i2c_wr(input logic [7:0] cmd, input logic [23:0] d,
    input int n);
    i2c_head(cmd);
    for (int k = 0; k < n; k++) begin
      mst_u.wr_byte(d[8*k +: 8], ack);
      check("data ack", ack, 32'h0);
    end
    mst_u.cond(1'b0, 1'b1);
  endtask

  task automatic i2c_rd(input logic [7:0] cmd, input int n,
    output logic [23:0] q);
    logic [7:0] b;
    q = 24'h0;
    i2c_head(cmd);
    mst_u.cond(1'b1, 1'b0);
    mst_u.wr_byte({BASE, addr_sel, 1'b1}, ack);
    check("read addr ack", ack, 32'h0);
    for (int k = 0; k < n; k++) begin
      mst_u.rd_byte(k == n - 1, b);
      q[8*k +: 8] = b;
    end
    mst_u.cond(1'b0, 1'b1);
  endtask

  initial begin
    rst_n = 1'b0;
    hw_rst_n = 1'b1;
    addr_sel = 1'b1;
    ext_q = 24'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_n(6);
    check("oe", p_oe, 32'h0);
    check("out", p_o, 32'h0);
    av(1'b1, OFS_EN, 32'hF, rd);
    av(1'b0, OFS_EN, 32'h0, rd);
    check("enable", rd, 32'hF);
    av(1'b0, 4'h6, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    @(posedge clk);
    mst_u.start();
    mst_u.wr_byte({BASE, 1'b0, 1'b0}, ack);
    check("foreign nack", ack, 32'h1);
    mst_u.cond(1'b0, 1'b1);
    i2c_wr(8'h84, 24'h5AC3A5, 3);
    wait_n(2);
    check("out", p_o, 32'h5AC3A5);
    check("oe idle", p_oe, 32'h0);
    i2c_wr(8'h8C, 24'hF0FF0F, 3);
    wait_n(2);
    check("oe", p_oe, 32'h0F00F0);
    i2c_rd(8'h8C, 3, rv);
    check("dir back", rv, 32'hF0FF0F);
    i2c_rd(8'h84, 3, rv);
    check("out back", rv, 32'h5AC3A5);
    @(posedge clk);
    ext_q <= 24'h003C00;
    wait_n(10);
    check("int set", int_n_oe, 32'h1);
    i2c_wr(8'h09, 24'h0000FF, 1);
    i2c_rd(8'h80, 2, rv);
    check("inputs", rv, 32'h00C3A0);
    wait_n(10);
    check("int read", int_n_oe, 32'h0);
    @(posedge clk);
    ext_q <= 24'h103C00;
    wait_n(10);
    check("int set", int_n_oe, 32'h1);
    @(posedge clk);
    ext_q <= 24'h003C00;
    wait_n(10);
    check("int back", int_n_oe, 32'h0);
    av(1'b0, OFS_STAT, 32'h0, rd);
    check("change event", rd[EV_CHG], 32'h1);
    wait_n(0);
    check("irq", irq, 32'h1);
    av(1'b1, OFS_EN, 32'h0, rd);
    wait_n(2);
    check("irq masked", irq, 32'h0);
    av(1'b1, OFS_CLR, 32'hF, rd);
    av(1'b1, OFS_EN, 32'hF, rd);
    av(1'b0, OFS_STAT, 32'h0, rd);
    check("status", rd, 32'h0);
    wait_n(2);
    check("irq clear", irq, 32'h0);
    @(posedge clk);
    ext_q <= 24'h803C00;
    hw_rst_n <= 1'b0;
    wait_n(12);
    check("pin rst out", p_o, 32'h0);
    check("pin rst oe", p_oe, 32'h0);
    check("pin rst int", int_n_oe, 32'h0);
    av(1'b0, OFS_EN, 32'h0, rd);
    check("enable kept", rd, 32'hF);
    hw_rst_n <= 1'b1;
    addr_sel <= 1'b0;
    wait_n(8);
    i2c_rd(8'h8C, 3, rv);
    check("dir default", rv, 32'hFFFFFF);
    i2c_rd(8'h84, 3, rv);
    check("out default", rv, 32'h0);
    end_of_test();
  end
endmodule // tb

bind ige_top ige_chk chk_u (.clk(clk), .rst_n(rst_n), .hw_rst_n(hw_rst_n),
  .sda_o(sda_o), .sda_oe(sda_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
  .p_i(p_i), .p_o(p_o), .p_oe(p_oe), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq));
